/* File: src/pdk_panel_ctrl.sv */
// panel display refresh, key scan and light pen hit latch behind an apb slave
// assumes panel pins, pen pins and chained bus inputs are asynchronous to clk_in
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps

module pdk_panel_ctrl (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // display board
    output pdk_pkg::pdk_panel_t panel_out,
    input wire logic scan_input_data_in,
    // light pen
    input wire logic pen_light_pulse_in,
    input wire logic pen_button_in,
    // chained pen bus
    output pdk_pkg::pdk_pen_bus_t pen_bus_out,
    input wire logic pen_hit_line_in,
    input wire logic pen_clear_line_in,
    // event level toward the processor
    output logic pen_button_event_out
);

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] raw_in;       // asynchronous pins
    logic [NSYNC-1:0] sync1_r;      // first stage, read only by sync2
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] sync3_r;
    logic [NSYNC-1:0] stable_r;     // accepted value
    logic [NSYNC-1:0] stable_nxt;
    logic key_data_s;
    logic pulse_s;
    logic button_s;
    logic hit_line_s;
    logic clear_line_s;
    logic [NSYNC-1:0] prev_r;       // stable value one cycle ago, for edges

    assign raw_in = {scan_input_data_in, pen_light_pulse_in, pen_button_in, pen_hit_line_in};

    // a change counts only once stages two and three agree
    always_comb begin
        for (int i = 0; i < NSYNC; i++) begin
            stable_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : stable_r[i];
        end
    end

    // idle pin levels are high, pulled up
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sync1_r <= '1;
            sync2_r <= '1;
            sync3_r <= '1;
            stable_r <= '1;
            prev_r <= '1;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            stable_r <= stable_nxt;
            prev_r <= stable_r;
        end
    end

    assign key_data_s = stable_r[3];
    assign pulse_s = stable_r[2];
    assign button_s = stable_r[1];
    assign hit_line_s = stable_r[0];

    // clear line has its own chain, idle low
    logic [2:0] clr_sync_r;
    logic [2:0] clr_sync_nxt;
    logic clr_stable_r;
    logic clr_stable_nxt;

    always_comb begin
        clr_sync_nxt = {clr_sync_r[1:0], pen_clear_line_in};
        clr_stable_nxt = (clr_sync_r[1] == clr_sync_r[2]) ? clr_sync_r[2] : clr_stable_r;
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            clr_sync_r <= 3'h0;
            clr_stable_r <= 1'b0;
        end else begin
            clr_sync_r <= clr_sync_nxt;
            clr_stable_r <= clr_stable_nxt;
        end
    end
    assign clear_line_s = clr_stable_r;

    // ****************************************
    // register state
    // ****************************************
    logic run_r, run_nxt;                       // continuous refresh enable
    logic step_r, step_nxt;                     // one scan slot pending
    logic hit_clr_r, hit_clr_nxt;               // software clear level
    logic follower_n_r, follower_n_nxt;         // low: unit is a follower
    logic [3:0] step_col_r, step_col_nxt;       // column for a single slot
    logic [3:0] ncols_r, ncols_nxt;             // columns in the multiplex
    logic button_flag_r, button_flag_nxt;       // sticky pen button event
    logic [7:0] seg_mem [0:127];                // eight segment bytes per column
    logic [7:0] key_mem [0:5];                  // latest byte of each key column
    logic pen_hit_level_n;                      // active-low hit as software reads it

    // ****************************************
    // sequencer state
    // ****************************************
    pdk_pkg::pdk_state_t state_r, state_nxt;
    logic [7:0] half_r, half_nxt;               // cycles left in this half period
    logic phase_r, phase_nxt;                   // panel clock level
    logic [6:0] bit_r, bit_nxt;                 // bit index in the frame
    logic [3:0] col_r, col_nxt;                 // column being driven
    logic blank_r, blank_nxt;
    logic key_sel_n_r, key_sel_n_nxt;
    logic data_r, data_nxt;                     // serial output bit
    logic [7:0] key_sr_r, key_sr_nxt;           // incoming key bits
    logic [7:0] key_last_r, key_last_nxt;
    logic slot_clear;                           // clear hit at slot start
    logic key_store;                            // write key_mem this cycle
    logic half_done;
    logic [6:0] bit_ahead;                      // frame bit presented next
    logic [3:0] frame_byte;
    logic [7:0] cur_byte;
    logic [3:0] col_next_run;

    // ****************************************
    // apb access
    // ****************************************
    logic acc_write, acc_read;
    logic in_seg, in_key, mapped;
    logic [11:0] key_off;
    logic [2:0] key_idx;

    always_comb begin
        acc_write = psel_in & penable_in & pwrite_in;
        acc_read = psel_in & penable_in & ~pwrite_in;
        in_seg = (paddr_in[11:9] == pdk_pkg::SEG_WINDOW);
        in_key = (paddr_in >= pdk_pkg::ADDR_KEY_BASE) && (paddr_in <= pdk_pkg::ADDR_KEY_END)
                 && (paddr_in[1:0] == 2'h0);
        key_off = paddr_in - pdk_pkg::ADDR_KEY_BASE;
        key_idx = key_off[4:2];
        mapped = in_seg | in_key | (paddr_in == pdk_pkg::ADDR_CTRL)
                 | (paddr_in == pdk_pkg::ADDR_STATUS) | (paddr_in == pdk_pkg::ADDR_NCOLS);
    end

    // zero wait states; unmapped words answer with an error
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~mapped;

    // read mux; zero wait states leave no cycle to register it
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0;
        if (in_seg) begin
            rdata_nxt[7:0] = seg_mem[paddr_in[8:2]];
        end else if (in_key) begin
            rdata_nxt[7:0] = key_mem[key_idx];
        end else if (paddr_in == pdk_pkg::ADDR_CTRL) begin
            rdata_nxt[pdk_pkg::CTRL_RUN] = run_r;
            rdata_nxt[pdk_pkg::CTRL_STEP] = step_r;
            rdata_nxt[pdk_pkg::CTRL_HIT_CLR] = hit_clr_r;
            rdata_nxt[pdk_pkg::CTRL_FOLLOWER_N] = follower_n_r;
            rdata_nxt[pdk_pkg::CTRL_COL_LSB +: 4] = step_col_r;
        end else if (paddr_in == pdk_pkg::ADDR_STATUS) begin
            rdata_nxt[pdk_pkg::STAT_BUSY] = (state_r != pdk_pkg::ST_IDLE);
            rdata_nxt[pdk_pkg::STAT_HIT_N] = pen_hit_level_n;
            rdata_nxt[pdk_pkg::STAT_BUTTON] = button_flag_r;
            rdata_nxt[pdk_pkg::STAT_RUN] = run_r;
            rdata_nxt[pdk_pkg::STAT_COL_LSB +: 4] = col_r;
            rdata_nxt[pdk_pkg::STAT_KEY_LSB +: 8] = key_last_r;
        end else if (paddr_in == pdk_pkg::ADDR_NCOLS) begin
            rdata_nxt[3:0] = ncols_r;
        end
    end

    // combinational read path: data valid in the access phase
    assign prdata_out = rdata_nxt;

    // ****************************************
    // control registers
    // ****************************************
    logic button_fall;
    assign button_fall = prev_r[1] & ~button_s;

    always_comb begin
        run_nxt = run_r;
        step_nxt = step_r;
        hit_clr_nxt = hit_clr_r;
        follower_n_nxt = follower_n_r;
        step_col_nxt = step_col_r;
        ncols_nxt = ncols_r;
        button_flag_nxt = button_flag_r;
        if (acc_write && paddr_in == pdk_pkg::ADDR_CTRL) begin
            run_nxt = pwdata_in[pdk_pkg::CTRL_RUN];
            step_nxt = step_r | pwdata_in[pdk_pkg::CTRL_STEP];
            hit_clr_nxt = pwdata_in[pdk_pkg::CTRL_HIT_CLR];
            follower_n_nxt = pwdata_in[pdk_pkg::CTRL_FOLLOWER_N];
            step_col_nxt = pwdata_in[pdk_pkg::CTRL_COL_LSB +: 4];
        end
        if (acc_write && paddr_in == pdk_pkg::ADDR_NCOLS) begin
            ncols_nxt = pwdata_in[3:0];
        end
        // write one to clear; a new event in the same cycle wins
        if (acc_write && paddr_in == pdk_pkg::ADDR_STATUS && pwdata_in[pdk_pkg::STAT_BUTTON]) begin
            button_flag_nxt = 1'b0;
        end
        if (button_fall) begin
            button_flag_nxt = 1'b1;
            run_nxt = 1'b0;
        end
        // the pending step is consumed when its slot starts
        if (state_r == pdk_pkg::ST_IDLE && !run_r && step_r) begin
            step_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            run_r <= 1'b0;
            step_r <= 1'b0;
            hit_clr_r <= 1'b0;
            follower_n_r <= 1'b1;
            step_col_r <= 4'h0;
            ncols_r <= pdk_pkg::NCOLS_RESET;
            button_flag_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            step_r <= step_nxt;
            hit_clr_r <= hit_clr_nxt;
            follower_n_r <= follower_n_nxt;
            step_col_r <= step_col_nxt;
            ncols_r <= ncols_nxt;
            button_flag_r <= button_flag_nxt;
        end
    end

    // memories need no reset; software fills seg_mem before running, key scans fill key_mem
    always_ff @(posedge clk_in) begin
        if (acc_write && in_seg) begin
            seg_mem[paddr_in[8:2]] <= pwdata_in[7:0];
        end
        if (key_store) begin
            key_mem[col_r[2:0]] <= key_sr_r;
        end
    end


    // ****************************************
    // refresh and key scan sequencer
    // ****************************************
    always_comb begin
        half_done = (half_r == 8'h0);
        // byte of the bit about to go out, so a byte boundary picks the next byte
        bit_ahead = (state_r == pdk_pkg::ST_SHIFT) ? bit_r + 7'h1 : 7'h0;
        frame_byte = bit_ahead[6:3];
        // segment bytes go first so the column byte lands in the first stage
        if (frame_byte < pdk_pkg::SEG_BYTE_COUNT) begin
            cur_byte = seg_mem[{col_r, frame_byte[2:0]}];
        end else begin
            cur_byte = {4'h0, col_r};
        end
        col_next_run = (col_r + 4'h1 >= ncols_r) ? 4'h0 : col_r + 4'h1;
    end

    always_comb begin
        state_nxt = state_r;
        half_nxt = half_done ? pdk_pkg::HALF_LAST : half_r - 8'h1;
        phase_nxt = phase_r;
        bit_nxt = bit_r;
        col_nxt = col_r;
        blank_nxt = blank_r;
        key_sel_n_nxt = key_sel_n_r;
        data_nxt = data_r;
        key_sr_nxt = key_sr_r;
        key_last_nxt = key_last_r;
        slot_clear = 1'b0;
        key_store = 1'b0;
        case (state_r)
            pdk_pkg::ST_IDLE: begin
                half_nxt = pdk_pkg::HALF_LAST;
                phase_nxt = 1'b1;
                if (run_r) begin
                    blank_nxt = 1'b1;
                    state_nxt = pdk_pkg::ST_BLANK;
                end else if (step_r) begin
                    // single column of a pen scan: hit flop cleared first
                    col_nxt = step_col_r;
                    slot_clear = 1'b1;
                    blank_nxt = 1'b1;
                    state_nxt = pdk_pkg::ST_BLANK;
                end
            end
            pdk_pkg::ST_BLANK: begin
                if (half_done) begin
                    bit_nxt = 7'h0;
                    phase_nxt = 1'b0;
                    data_nxt = cur_byte[~bit_ahead[2:0]];
                    state_nxt = pdk_pkg::ST_SHIFT;
                end
            end
            pdk_pkg::ST_SHIFT: begin
                if (half_done) begin
                    phase_nxt = ~phase_r;
                    if (phase_r) begin
                        // falling edge: next bit, msb first
                        if (bit_r == pdk_pkg::FRAME_BITS_LAST) begin
                            state_nxt = pdk_pkg::ST_UNBLANK;
                            phase_nxt = 1'b1;
                        end else begin
                            bit_nxt = bit_r + 7'h1;
                        end
                    end
                end
                if (half_done && phase_r && bit_r != pdk_pkg::FRAME_BITS_LAST) begin
                    data_nxt = cur_byte[~bit_ahead[2:0]];
                end
            end
            pdk_pkg::ST_UNBLANK: begin
                if (half_done) begin
                    blank_nxt = 1'b0;
                    state_nxt = pdk_pkg::ST_KEYSEL;
                end
            end
            pdk_pkg::ST_KEYSEL: begin
                if (half_done) begin
                    key_sel_n_nxt = 1'b0;
                    bit_nxt = 7'h0;
                    phase_nxt = 1'b0;
                    state_nxt = pdk_pkg::ST_KEYSHIFT;
                end
            end
            pdk_pkg::ST_KEYSHIFT: begin
                if (half_done) begin
                    phase_nxt = ~phase_r;
                    if (!phase_r) begin
                        // sample just before the rising edge moves the rows
                        key_sr_nxt = {key_sr_r[6:0], key_data_s};
                    end else if (bit_r[2:0] == pdk_pkg::KEY_BITS_LAST) begin
                        // park high, else the display clock dips once select returns
                        phase_nxt = 1'b1;
                        state_nxt = pdk_pkg::ST_KEYEND;
                    end else begin
                        bit_nxt = bit_r + 7'h1;
                    end
                end
            end
            pdk_pkg::ST_KEYEND: begin
                key_sel_n_nxt = 1'b1;
                key_last_nxt = key_sr_r;
                key_store = (col_r < pdk_pkg::KEY_COLS);
                if (run_r) begin
                    col_nxt = col_next_run;
                end
                state_nxt = pdk_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = pdk_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= pdk_pkg::ST_IDLE;
            half_r <= pdk_pkg::HALF_LAST;
            phase_r <= 1'b1;
            bit_r <= 7'h0;
            col_r <= 4'h0;
            blank_r <= 1'b0;
            key_sel_n_r <= 1'b1;
            data_r <= 1'b1;
            key_sr_r <= 8'h0;
            key_last_r <= 8'h0;
        end else begin
            state_r <= state_nxt;
            half_r <= half_nxt;
            phase_r <= phase_nxt;
            bit_r <= bit_nxt;
            col_r <= col_nxt;
            blank_r <= blank_nxt;
            key_sel_n_r <= key_sel_n_nxt;
            data_r <= data_nxt;
            key_sr_r <= key_sr_nxt;
            key_last_r <= key_last_nxt;
        end
    end

    // ****************************************
    // panel pin steering
    // ****************************************
    // the idle clock level is high on both paths
    always_comb begin
        panel_out.blank = blank_r;
        panel_out.display_shift_clock = key_sel_n_r ? phase_r : 1'b1;
        panel_out.scan_input_clock = key_sel_n_r ? 1'b1 : phase_r;
        panel_out.display_serial_data = data_r;
        panel_out.display_data_oe = key_sel_n_r;
        panel_out.scan_data_oe = ~key_sel_n_r;
        panel_out.scan_select_n = key_sel_n_r;
    end

    // ****************************************
    // light pen hit latch
    // ****************************************
    logic hit_r, hit_nxt;
    logic pulse_rise;
    logic clear_any;
    logic clr_pulse_r;                                                  // slot clear, one cycle

    assign pulse_rise = ~prev_r[2] & pulse_s;
    // a follower's clear reaches the master over the shared line
    assign clear_any = hit_clr_r | clr_pulse_r | (follower_n_r & clear_line_s);

    always_comb begin
        hit_nxt = hit_r;
        if (clear_any) begin
            hit_nxt = 1'b0;
        end
        if (pulse_rise) begin
            hit_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            hit_r <= 1'b0;
            clr_pulse_r <= 1'b0;
        end else begin
            hit_r <= hit_nxt;
            clr_pulse_r <= slot_clear;
        end
    end

    // a follower watches the master's flop on the shared line
    assign pen_hit_level_n = follower_n_r ? ~hit_r : hit_line_s;

    always_comb begin
        pen_bus_out.hit_out = ~hit_r;
        pen_bus_out.hit_oe = follower_n_r;
        pen_bus_out.clear_out = 1'b1;
        pen_bus_out.clear_oe = hit_clr_r | clr_pulse_r;
    end

    assign pen_button_event_out = button_flag_r;

endmodule : pdk_panel_ctrl

/* File: src/pdk_pkg.sv */
// package for the front panel display, key scan and light pen controller
// assumes a 125 MHz system clock and a 32-bit apb register bus
package pdk_pkg;

    // ****************************************
    // clock and shift timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;                  // system clock period
    localparam int SHIFT_HALF_NS = 500;                // least half period of panel clock
    localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] HALF_LAST = 8'(SHIFT_HALF_CYC - 1);

    // ****************************************
    // frame geometry
    // ****************************************
    localparam logic [6:0] FRAME_BITS_LAST = 7'h47;    // nine bytes, 72 bits
    localparam logic [3:0] SEG_BYTE_COUNT = 4'h8;      // segment bytes before column byte
    localparam logic [2:0] KEY_BITS_LAST = 3'h7;       // eight key row bits
    localparam logic [3:0] KEY_COLS = 4'h6;            // key array columns
    localparam logic [3:0] NCOLS_RESET = 4'hf;         // multiplex columns after reset

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_NCOLS = 12'h008;
    localparam logic [11:0] ADDR_KEY_BASE = 12'h010;   // six words, one per key column
    localparam logic [11:0] ADDR_KEY_END = 12'h024;
    localparam logic [2:0] SEG_WINDOW = 3'h1;          // addr[11:9]: 0x200..0x3fc

    // ctrl fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STEP = 1;
    localparam int CTRL_HIT_CLR = 2;
    localparam int CTRL_FOLLOWER_N = 3;
    localparam int CTRL_COL_LSB = 4;
    // status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_HIT_N = 1;
    localparam int STAT_BUTTON = 2;
    localparam int STAT_RUN = 3;
    localparam int STAT_COL_LSB = 4;
    localparam int STAT_KEY_LSB = 8;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_BLANK, ST_SHIFT, ST_UNBLANK, ST_KEYSEL, ST_KEYSHIFT, ST_KEYEND
    } pdk_state_t;

    // pins toward the display board
    typedef struct packed {
        logic blank;                // high disables segment drivers; its fall loads key register
        logic display_shift_clock;
        logic display_serial_data;
        logic display_data_oe;
        logic scan_input_clock;
        logic scan_data_oe;         // key data driver enable
        logic scan_select_n;        // low selects the key path
    } pdk_panel_t;

    // pins of the chained light pen bus
    typedef struct packed {
        logic hit_out;
        logic hit_oe;
        logic clear_out;
        logic clear_oe;
    } pdk_pen_bus_t;

endpackage : pdk_pkg

/* File: sim/pdk_panel_props.sv */
// checker for panel steering, frame timing and pen latch
// assumes a bind onto pdk_panel_ctrl
`timescale 1ns/10ps
module pdk_panel_props (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // watched pins
    input wire pdk_pkg::pdk_panel_t panel_out,
    input wire pdk_pkg::pdk_pen_bus_t pen_bus_out,
    input wire logic pen_light_pulse_in,
    input wire logic pen_button_in,
    input wire logic pen_button_event_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    disp_steer_a: assert property (panel_out.scan_select_n |-> panel_out.scan_input_clock && panel_out.display_data_oe)
        else $error("key clock moves on display path");
    key_steer_a: assert property (!panel_out.scan_select_n |-> panel_out.display_shift_clock
        && panel_out.scan_data_oe && !panel_out.display_data_oe) else $error("display path active in key scan");
    blank_shift_a: assert property ($fell(panel_out.display_shift_clock) |-> panel_out.blank)
        else $error("display clock runs unblanked");
    key_after_a: assert property ($fell(panel_out.scan_select_n) |-> !panel_out.blank)
        else $error("key select before blank fell");
    bit_stable_a: assert property ($rose(panel_out.display_shift_clock) |-> $stable(panel_out.display_serial_data))
        else $error("data moves on sampling edge");
    blank_hold_a: assert property ($fell(panel_out.blank) |-> $past(panel_out.blank, 60))
        else $error("blank too short");
    hit_set_a: assert property ($fell(pen_bus_out.hit_out) |-> $past(pen_light_pulse_in, 2))
        else $error("hit set without pulse edge");
    button_evt_a: assert property ($fell(pen_button_in) |-> ##[1:8] pen_button_event_out)
        else $error("button press missed");
endmodule : pdk_panel_props
bind pdk_panel_ctrl pdk_panel_props u_pdk_panel_props (.clk_in(clk_in), .resetn_in(resetn_in),
    .panel_out(panel_out), .pen_bus_out(pen_bus_out), .pen_light_pulse_in(pen_light_pulse_in),
    .pen_button_in(pen_button_in), .pen_button_event_out(pen_button_event_out));

/* File: sim/pdk_board_model.sv */
// display board model: segment chain capture and key row register
// assumes panel pins come straight from the controller
`timescale 1ns/10ps
module pdk_board_model (
    // from controller, key rows from bench
    input wire pdk_pkg::pdk_panel_t panel_in,
    input wire logic [7:0] rows_in,
    // to controller and bench
    output logic scan_input_data_out,
    output logic [71:0] frame_out
);
    logic [7:0] key_sr = 8'hff; // key row shift register
    initial frame_out = '0;
    // segment chain takes one bit per rising display clock
    always @(posedge panel_in.display_shift_clock)
        if (panel_in.blank) frame_out <= {frame_out[70:0], panel_in.display_serial_data};
    // rows captured as blanking ends, then shifted msb first
    always @(negedge panel_in.blank) key_sr <= rows_in;
    always @(posedge panel_in.scan_input_clock) key_sr <= {key_sr[6:0], ~key_sr[0]};
    // released driver shows the inverse, never a held level
    assign scan_input_data_out = panel_in.scan_data_oe ? key_sr[7] : ~key_sr[7];
endmodule : pdk_board_model

/* File: sim/panel_display_keyscan_lightpen_test.sv */
// self-checking bench for pdk_panel_ctrl with board model
// assumes the checker is bound from its own file
`timescale 1ns/10ps
module panel_display_keyscan_lightpen_test;
    logic clk_in = 0, resetn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out, q;
    logic pready_out, pslverr_out, e, key_data, btn_evt, pulse = 1, btn = 1, hit_line = 1, clr_line = 0;
    logic [7:0] rows = 8'h5a;
    logic [71:0] frame, x;
    pdk_pkg::pdk_panel_t panel;
    pdk_pkg::pdk_pen_bus_t pen_bus;
    int fail_count = 0, checked = 0, cycles = 0;
    always #4 clk_in = ~clk_in;
    pdk_panel_ctrl u_pdk_panel_ctrl (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .panel_out(panel),
        .scan_input_data_in(key_data), .pen_light_pulse_in(pulse), .pen_button_in(btn),
        .pen_bus_out(pen_bus), .pen_hit_line_in(hit_line), .pen_clear_line_in(clr_line),
        .pen_button_event_out(btn_evt));
    pdk_board_model u_pdk_board_model (.panel_in(panel), .rows_in(rows), .scan_input_data_out(key_data),
        .frame_out(frame));
    task chk(input string n, input logic [71:0] xp, input logic [71:0] g);
        checked++;
        if (g !== xp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, xp, g);
        end
    endtask : chk
    // apb master: setup, access, wait for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask : apb
    task wait_idle;
        repeat (4) @(posedge clk_in);
        do apb(0, pdk_pkg::ADDR_STATUS, 0); while (q[0] !== 1'b0);
    endtask : wait_idle
    // one stepped column: frame content and key readback
    task t_frame(input logic [3:0] col);
        rows <= 8'h5a ^ col;
        for (int b = 0; b < 8; b++) begin
            apb(1, 12'h200 + 12'((col * 8 + b) * 4), 32'(8'h81 + b * 19));
            x = {x[63:0], 8'(8'h81 + b * 19)};
        end
        apb(1, pdk_pkg::ADDR_CTRL, {24'h0, col, 4'ha});
        wait_idle;
        chk("frame", {x[63:0], 4'h0, col}, frame);
        chk("key byte", rows, q[15:8]);
        apb(0, pdk_pkg::ADDR_KEY_BASE + 12'(col * 4), 0);
        chk("key store", rows, q[7:0]);
    endtask : t_frame
    // pen pulse low for about 15 us, then let the hit settle
    task pen_flash;
        pulse <= 0;
        repeat (1875) @(posedge clk_in);
        pulse <= 1;
        repeat (8) @(posedge clk_in);
    endtask : pen_flash
    task t_pen;
        pen_flash;
        apb(0, pdk_pkg::ADDR_STATUS, 0);
        chk("hit set", 0, q[1]);
        apb(1, pdk_pkg::ADDR_CTRL, 32'hc);
        @(posedge clk_in);
        chk("clear drive", 1, pen_bus.clear_oe);
        apb(1, pdk_pkg::ADDR_CTRL, 32'h8);
        apb(0, pdk_pkg::ADDR_STATUS, 0);
        chk("hit clear", 1, q[1]);
        pen_flash;
        clr_line <= 1;
        repeat (8) @(posedge clk_in);
        clr_line <= 0;
        apb(0, pdk_pkg::ADDR_STATUS, 0);
        chk("line clear", 1, q[1]);
        hit_line <= 0;
        apb(1, pdk_pkg::ADDR_CTRL, 32'h0);
        repeat (8) @(posedge clk_in);
        apb(0, pdk_pkg::ADDR_STATUS, 0);
        chk("follower hit", 0, q[1]);
        chk("follower drive", 0, pen_bus.hit_oe);
        apb(1, pdk_pkg::ADDR_CTRL, 32'h8);
    endtask : t_pen
    task t_button;
        apb(1, pdk_pkg::ADDR_CTRL, 32'h9);
        repeat (20) @(posedge clk_in);
        btn <= 0;
        repeat (10) @(posedge clk_in);
        chk("button flag", 1, btn_evt);
        btn <= 1;
        wait_idle;
        chk("run stopped", 0, q[3]);
        apb(1, pdk_pkg::ADDR_STATUS, 32'h4);
        apb(0, pdk_pkg::ADDR_STATUS, 0);
        chk("button clear", 0, q[2]);
        apb(0, 12'h100, 0);
        chk("unmapped", 1, e);
    endtask : t_button
    task give_verdict;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (20) @(posedge clk_in);
        chk("reset select", 1, panel.scan_select_n);
        chk("reset oe", 1, panel.display_data_oe);
        resetn_in <= 1;
        t_frame(4'h0);
        t_frame(4'h5);
        t_pen;
        t_button;
        give_verdict;
    end
endmodule : panel_display_keyscan_lightpen_test
